// *** tmr_timer.sv ***
// Dual 32-bit timer with prescaler, four match, two capture and PWM, behind an APB slave
`timescale 1ns/1ps
`default_nettype none

module tmr_unit
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register access
  input wire tmr_pkg::tmr_wr_type wr,
  input wire logic [tmr_pkg::OW-1:0] rd_off,
  output logic [tmr_pkg::DW-1:0] rd_data,
  // Pins
  input wire logic [tmr_pkg::N_CAP-1:0] cap_in,
  output logic [tmr_pkg::N_MATCH-1:0] mat_out,
  output logic irq
);
  import tmr_pkg::*;

  // ****************************************
  // Capture input synchronisers and edges
  // ****************************************
  logic [N_CAP-1:0] cap_s1_r, cap_s2_r, cap_d_r;
  logic [N_CAP-1:0] rise, fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_s1_r <= '0;
      cap_s2_r <= '0;
      cap_d_r <= '0;
    end else begin
      cap_s1_r <= cap_in;
      cap_s2_r <= cap_s1_r;
      cap_d_r <= cap_s2_r;
    end
  end

  assign rise = cap_s2_r & ~cap_d_r;
  assign fall = ~cap_s2_r & cap_d_r;

  // ****************************************
  // Registers
  // ****************************************
  logic [N_IRQ-1:0] ir_r;
  logic [1:0] tcr_r;
  logic [DW-1:0] tc_r, pr_r, pc_r;
  logic [MCR_STRIDE*N_MATCH-1:0] mcr_r;
  logic [DW-1:0] mr_r [N_MATCH];
  logic [CCR_STRIDE*N_CAP-1:0] ccr_r;
  logic [DW-1:0] cr_r [N_CAP];
  logic [EMR_W-1:0] emr_r;
  logic [COUNT_SOURCE_CONTROL_W-1:0] count_source_control_r;
  logic [N_MATCH-1:0] pwmc_r, pwm_r;
  logic [N_MATCH-1:0] eq, eq_prev_r, match_evt;
  logic zero_prev_r;

  function automatic logic wr_hit(input tmr_wr_type w, input logic [OW-1:0] off);
    return w.we && (w.off == off);
  endfunction

  // ****************************************
  // Count source and events
  // ****************************************
  tmr_cnt_mode_type mode;
  logic sel_rise, sel_fall, cnt_edge, clr_edge, cap_clear;
  logic running, pre_roll, tick, restart;
  logic [N_MATCH-1:0] rst_sel, stop_sel, int_sel;
  logic [N_CAP-1:0] cap_evt;

  assign mode = tmr_cnt_mode_type'(count_source_control_r[COUNT_SOURCE_CONTROL_MODE +: 2]);
  // Input select values other than 0 and 1 leave no source, so no counting in the three edge modes
  assign sel_rise = (count_source_control_r[COUNT_SOURCE_CONTROL_SEL +: 2] < 2'(N_CAP)) ? rise[count_source_control_r[COUNT_SOURCE_CONTROL_SEL]] : 1'b0;
  assign sel_fall = (count_source_control_r[COUNT_SOURCE_CONTROL_SEL +: 2] < 2'(N_CAP)) ? fall[count_source_control_r[COUNT_SOURCE_CONTROL_SEL]] : 1'b0;

  always_comb begin
    case (mode)
      CNT_RISE: cnt_edge = sel_rise;
      CNT_FALL: cnt_edge = sel_fall;
      CNT_BOTH: cnt_edge = sel_rise | sel_fall;
      default: cnt_edge = 1'b0;
    endcase
  end

  // Clear edge: bit 1 picks the channel, bit 0 picks falling over rising
  assign clr_edge = count_source_control_r[COUNT_SOURCE_CONTROL_CLR_EDGE] ? fall[count_source_control_r[COUNT_SOURCE_CONTROL_CLR_EDGE+1]] : rise[count_source_control_r[COUNT_SOURCE_CONTROL_CLR_EDGE+1]];
  assign cap_clear = count_source_control_r[COUNT_SOURCE_CONTROL_CLR_EN] & clr_edge;

  genvar gi;
  generate
    for (gi = 0; gi < N_MATCH; gi++) begin : g_match
      assign eq[gi] = (tc_r == mr_r[gi]);
      assign match_evt[gi] = eq[gi] & ~eq_prev_r[gi];
      assign int_sel[gi] = mcr_r[gi*MCR_STRIDE + MCR_INT];
      assign rst_sel[gi] = mcr_r[gi*MCR_STRIDE + MCR_RST];
      assign stop_sel[gi] = mcr_r[gi*MCR_STRIDE + MCR_STOP];
    end
    for (gi = 0; gi < N_CAP; gi++) begin : g_cap
      assign cap_evt[gi] = (rise[gi] & ccr_r[gi*CCR_STRIDE + CCR_RISE])
                         | (fall[gi] & ccr_r[gi*CCR_STRIDE + CCR_FALL]);
    end
  endgenerate

  // A stop in this cycle also holds back the tick, so the count never passes the stop value
  assign running = tcr_r[TCR_EN] & ~tcr_r[TCR_RST] & ~|(match_evt & stop_sel);
  assign pre_roll = (pc_r == pr_r);
  assign tick = running & ((mode == CNT_TIMER) ? pre_roll : cnt_edge);
  assign restart = (tc_r == RST_VAL) & ~zero_prev_r;

  // ****************************************
  // Control and configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcr_r <= '0;
    end else if (wr_hit(wr, OFF_TCR)) begin
      tcr_r <= wr.data[1:0];
    end else if (|(match_evt & stop_sel)) begin
      tcr_r[TCR_EN] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pr_r <= RST_VAL;
      mcr_r <= '0;
      ccr_r <= '0;
      count_source_control_r <= '0;
      pwmc_r <= '0;
    end else begin
      if (wr_hit(wr, OFF_PR)) pr_r <= wr.data;
      if (wr_hit(wr, OFF_MCR)) mcr_r <= wr.data[MCR_STRIDE*N_MATCH-1:0];
      if (wr_hit(wr, OFF_CCR)) ccr_r <= wr.data[CCR_STRIDE*N_CAP-1:0];
      if (wr_hit(wr, OFF_COUNT_SOURCE_CONTROL)) count_source_control_r <= wr.data[COUNT_SOURCE_CONTROL_W-1:0];
      if (wr_hit(wr, OFF_PWMC)) pwmc_r <= wr.data[N_MATCH-1:0];
    end
  end

  generate
    for (gi = 0; gi < N_MATCH; gi++) begin : g_mr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mr_r[gi] <= RST_VAL;
        end else if (wr_hit(wr, OFF_MR0 + OW'(gi) * OFF_STEP)) begin
          mr_r[gi] <= wr.data;
        end
      end
    end
  endgenerate

  // ****************************************
  // Prescaler and count
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= RST_VAL;
    end else if (wr_hit(wr, OFF_PC)) begin
      pc_r <= wr.data;
    end else if (tcr_r[TCR_RST] || cap_clear) begin
      pc_r <= RST_VAL;
    end else if (running && mode == CNT_TIMER) begin
      pc_r <= pre_roll ? RST_VAL : pc_r + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_r <= RST_VAL;
    end else if (wr_hit(wr, OFF_TC)) begin
      tc_r <= wr.data;
    end else if (tcr_r[TCR_RST] || cap_clear) begin
      tc_r <= RST_VAL;
    end else if (tick) begin
      // Reset only at the period's end, so the matched value lasts a full period
      tc_r <= |(eq & rst_sel) ? RST_VAL : tc_r + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Count and match values both start at zero: no false match event out of reset
      eq_prev_r <= '1;
      zero_prev_r <= 1'b1;
    end else begin
      eq_prev_r <= eq;
      zero_prev_r <= (tc_r == RST_VAL);
    end
  end

  // ****************************************
  // Capture registers and status flags
  // ****************************************
  generate
    for (gi = 0; gi < N_CAP; gi++) begin : g_cr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cr_r[gi] <= RST_VAL;
        end else if (cap_evt[gi]) begin
          cr_r[gi] <= tc_r;
        end
      end
    end
  endgenerate

  logic [N_IRQ-1:0] ir_set, ir_clr;
  logic [N_CAP-1:0] cap_int;

  generate
    for (gi = 0; gi < N_CAP; gi++) begin : g_capint
      assign cap_int[gi] = cap_evt[gi] & ccr_r[gi*CCR_STRIDE + CCR_INT];
    end
  endgenerate

  assign ir_set = {cap_int, match_evt & int_sel};
  assign ir_clr = wr_hit(wr, OFF_IR) ? wr.data[N_IRQ-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_r <= '0;
    end else begin
      // A new event in the clearing cycle is kept
      ir_r <= (ir_r & ~ir_clr) | ir_set;
    end
  end

  assign irq = |ir_r;

  // ****************************************
  // External match and PWM outputs
  // ****************************************
  logic [EMR_W-1:0] emr_nxt;

  always_comb begin
    emr_nxt = wr_hit(wr, OFF_EMR) ? wr.data[EMR_W-1:0] : emr_r;
    for (int i = 0; i < N_MATCH; i++) begin
      if (match_evt[i]) begin
        case (tmr_em_act_type'(emr_r[EMR_CTL + 2*i +: 2]))
          EM_CLEAR: emr_nxt[i] = 1'b0;
          EM_SET: emr_nxt[i] = 1'b1;
          EM_TOGGLE: emr_nxt[i] = ~emr_r[i];
          default: emr_nxt[i] = emr_nxt[i];
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emr_r <= '0;
    end else begin
      emr_r <= emr_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_r <= '0;
    end else begin
      for (int i = 0; i < N_MATCH; i++) begin
        if (match_evt[i]) begin
          pwm_r[i] <= 1'b1;
        end else if (restart && mr_r[i] != RST_VAL) begin
          pwm_r[i] <= 1'b0;
        end
      end
    end
  end

  assign mat_out = (pwmc_r & pwm_r) | (~pwmc_r & emr_r[N_MATCH-1:0]);

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_data = RST_VAL;
    case (rd_off)
      OFF_IR: rd_data[N_IRQ-1:0] = ir_r;
      OFF_TCR: rd_data[1:0] = tcr_r;
      OFF_TC: rd_data = tc_r;
      OFF_PR: rd_data = pr_r;
      OFF_PC: rd_data = pc_r;
      OFF_MCR: rd_data[MCR_STRIDE*N_MATCH-1:0] = mcr_r;
      OFF_CCR: rd_data[CCR_STRIDE*N_CAP-1:0] = ccr_r;
      OFF_CR0: rd_data = cr_r[0];
      OFF_CR1: rd_data = cr_r[1];
      OFF_EMR: rd_data[EMR_W-1:0] = emr_r;
      OFF_COUNT_SOURCE_CONTROL: rd_data[COUNT_SOURCE_CONTROL_W-1:0] = count_source_control_r;
      OFF_PWMC: rd_data[N_MATCH-1:0] = pwmc_r;
      default: begin
        if (rd_off >= OFF_MR0 && rd_off <= OFF_MR3) begin
          rd_data = mr_r[2'((rd_off - OFF_MR0) >> 2)];
        end
      end
    endcase
  end
endmodule // tmr_unit

module tmr_timer
  import tmr_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Unit 0 pins
  input wire logic [tmr_pkg::N_CAP-1:0] capture_inputs_unit0,
  output logic [tmr_pkg::N_MATCH-1:0] match_outputs_unit0,
  output logic irq_unit0,
  // Unit 1 pins
  input wire logic [tmr_pkg::N_CAP-1:0] capture_inputs_unit1,
  output logic [tmr_pkg::N_MATCH-1:0] match_outputs_unit1,
  output logic irq_unit1
);
  import tmr_pkg::*;

  logic [OW-1:0] off;
  logic unit, known;
  tmr_wr_type wr [2];
  logic [DW-1:0] rd [2];
  logic [DW-1:0] prdata_r;

  assign off = paddr[OW-1:0];
  assign unit = paddr[UNIT_BIT];
  assign known = tmr_reg_known(off) && (paddr[1:0] == 2'h0) && (paddr[31:UNIT_BIT+1] == '0)
               && (paddr[UNIT_BIT-1:OW] == '0);

  // Zero-wait slave: read data is caught in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= RST_VAL;
    end else if (psel && !penable) begin
      prdata_r <= known ? rd[unit] : RST_VAL;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~known;

  generate
    for (genvar u = 0; u < 2; u++) begin : g_unit
      assign wr[u].we = psel & penable & pwrite & known & (unit == 1'(u));
      assign wr[u].off = off;
      assign wr[u].data = pwdata;
    end
  endgenerate

  tmr_unit u_unit0 (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr[0]),
    .rd_off(off),
    .rd_data(rd[0]),
    .cap_in(capture_inputs_unit0),
    .mat_out(match_outputs_unit0),
    .irq(irq_unit0)
  );

  tmr_unit u_unit1 (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr[1]),
    .rd_off(off),
    .rd_data(rd[1]),
    .cap_in(capture_inputs_unit1),
    .mat_out(match_outputs_unit1),
    .irq(irq_unit1)
  );
endmodule // tmr_timer
`default_nettype wire

// *** tmr_pkg.sv ***
// Package: register map, field layout and carrier types of the dual 32-bit match/capture timer
`default_nettype none
package tmr_pkg;
  localparam int DW = 32;
  localparam int OW = 8;
  localparam int UNIT_BIT = 12;
  localparam int N_MATCH = 4;
  localparam int N_CAP = 2;
  localparam int N_IRQ = N_MATCH + N_CAP;
  localparam logic [DW-1:0] RST_VAL = 32'h0000_0000;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [OW-1:0] OFF_IR = 8'h00;
  localparam logic [OW-1:0] OFF_TCR = 8'h04;
  localparam logic [OW-1:0] OFF_TC = 8'h08;
  localparam logic [OW-1:0] OFF_PR = 8'h0c;
  localparam logic [OW-1:0] OFF_PC = 8'h10;
  localparam logic [OW-1:0] OFF_MCR = 8'h14;
  localparam logic [OW-1:0] OFF_MR0 = 8'h18;
  localparam logic [OW-1:0] OFF_MR3 = 8'h24;
  localparam logic [OW-1:0] OFF_CCR = 8'h28;
  localparam logic [OW-1:0] OFF_CR0 = 8'h2c;
  localparam logic [OW-1:0] OFF_CR1 = 8'h30;
  localparam logic [OW-1:0] OFF_EMR = 8'h3c;
  localparam logic [OW-1:0] OFF_COUNT_SOURCE_CONTROL = 8'h70;
  localparam logic [OW-1:0] OFF_PWMC = 8'h74;
  localparam logic [OW-1:0] OFF_STEP = 8'h04;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int TCR_EN = 0;
  localparam int TCR_RST = 1;
  localparam int MCR_STRIDE = 3;
  localparam int MCR_INT = 0;
  localparam int MCR_RST = 1;
  localparam int MCR_STOP = 2;
  localparam int CCR_STRIDE = 3;
  localparam int CCR_RISE = 0;
  localparam int CCR_FALL = 1;
  localparam int CCR_INT = 2;
  localparam int COUNT_SOURCE_CONTROL_MODE = 0;
  localparam int COUNT_SOURCE_CONTROL_SEL = 2;
  localparam int COUNT_SOURCE_CONTROL_CLR_EN = 4;
  localparam int COUNT_SOURCE_CONTROL_CLR_EDGE = 5;
  localparam int COUNT_SOURCE_CONTROL_W = 7;
  localparam int EMR_CTL = 4;
  localparam int EMR_W = 12;
  localparam int IR_CAP = 4;
  typedef enum logic [1:0] {
    CNT_TIMER = 2'h0,
    CNT_RISE = 2'h1,
    CNT_FALL = 2'h2,
    CNT_BOTH = 2'h3
  } tmr_cnt_mode_type;
  typedef enum logic [1:0] {
    EM_NONE = 2'h0,
    EM_CLEAR = 2'h1,
    EM_SET = 2'h2,
    EM_TOGGLE = 2'h3
  } tmr_em_act_type;
  typedef struct packed {
    logic we;
    logic [OW-1:0] off;
    logic [DW-1:0] data;
  } tmr_wr_type;
  function automatic logic tmr_reg_known(input logic [OW-1:0] off);
    return (off <= OFF_CR1) || (off == OFF_EMR) || (off == OFF_COUNT_SOURCE_CONTROL) || (off == OFF_PWMC);
  endfunction
endpackage
`default_nettype wire

// *** tmr_checker.sv ***
// Concurrent checks on the timer's bus and interrupt ports
`timescale 1ns/1ps
`default_nettype none
module tmr_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic [3:0] match_outputs_unit1,
  input wire logic irq_unit0,
  input wire logic irq_unit1
);
  logic acc;
  logic clr0;
  logic clr1;
  assign acc = psel && penable;
  assign clr0 = acc && pwrite && paddr == 32'h0;
  assign clr1 = acc && pwrite && paddr == 32'h1000;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_align; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_align: assert property (p_align) else $error("unaligned not refused");
  property p_hole; acc && !pwrite && paddr[7:0] == 8'h34 |-> pslverr && prdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("hole not refused");
  property p_known; acc && paddr == 32'h1008 |-> !pslverr; endproperty
  a_known: assert property (p_known) else $error("mapped access refused");
  property p_clr0; $fell(irq_unit0) |-> $past(clr0); endproperty
  a_clr0: assert property (p_clr0) else $error("irq0 fell without clear");
  property p_clr1; $fell(irq_unit1) |-> $past(clr1); endproperty
  a_clr1: assert property (p_clr1) else $error("irq1 fell without clear");
  // Status is caught at setup, so compare with the line one edge back
  property p_stat; acc && !pwrite && paddr == 32'h0 |-> (|prdata[5:0]) == $past(irq_unit0); endproperty
  a_stat: assert property (p_stat) else $error("status and irq differ");
  property p_hold; !psel ##1 !psel |-> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved while idle");
  c_irq: cover property ($rose(irq_unit0));
  c_err: cover property (acc && pslverr);
  c_pwm: cover property ($rose(match_outputs_unit1[0]));
endmodule // tmr_checker
bind tmr_timer tmr_checker tmr_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .match_outputs_unit1, .irq_unit0, .irq_unit1);
`default_nettype wire

// *** tmr_pins.sv ***
// Far-side pin model: capture sources and match output watcher
`timescale 1ns/1ps
`default_nettype none
module tmr_pins (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests
  input wire logic [1:0] cap_req,
  input wire logic [1:0] lag,
  input wire logic count_en,
  // Pins
  input wire logic [3:0] mat,
  output logic [1:0] cap,
  output logic [15:0] high_cycles,
  output logic [7:0] rises1
);
  logic [1:0] wait_r;
  logic mat1_r;
  // Pins follow the request after a lag, so slow sources are seen too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= 2'h0;
      wait_r <= 2'h0;
    end else if (cap != cap_req) begin
      if (wait_r >= lag) begin
        cap <= cap_req;
        wait_r <= 2'h0;
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_cycles <= 16'h0;
      rises1 <= 8'h0;
      mat1_r <= 1'h0;
    end else begin
      mat1_r <= mat[1];
      if (count_en && mat[0]) high_cycles <= high_cycles + 16'h1;
      if (mat[1] && !mat1_r) rises1 <= rises1 + 8'h1;
    end
  end
endmodule // tmr_pins
`default_nettype wire

// *** tmr_timer_tb.sv ***
// Self-checking bench for the dual timer
`timescale 1ns/1ps
`default_nettype none
module tmr_timer_tb;
  import tmr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq0, irq1, cnt_en;
  logic [31:0] paddr, pwdata, prdata, seed;
  logic [N_CAP-1:0] cap0, cap1, req0, req1, lag;
  logic [N_MATCH-1:0] mat0, mat1;
  logic [15:0] hi0, hi1;
  logic [7:0] rs0, rs1;
  logic [31:0] q[$];
  int fail_count, n_compared, n;
  tmr_timer tmr_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_inputs_unit0(cap0), .match_outputs_unit0(mat0), .irq_unit0(irq0),
    .capture_inputs_unit1(cap1), .match_outputs_unit1(mat1), .irq_unit1(irq1));
  tmr_pins tmr_pins_i0 (.pclk(pclk), .presetn(presetn), .cap_req(req0), .lag(lag), .count_en(cnt_en),
    .mat(mat0), .cap(cap0), .high_cycles(hi0), .rises1(rs0));
  tmr_pins tmr_pins_i1 (.pclk(pclk), .presetn(presetn), .cap_req(req1), .lag(lag), .count_en(cnt_en),
    .mat(mat1), .cap(cap1), .high_cycles(hi1), .rises1(rs1));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic sig(input int s);
    case (s)
      0: return irq0;
      1: return mat0[1];
      2: return cap1[1];
      3: return !cap1[1];
      4: return !cap0[0];
      default: return cap0[0];
    endcase
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_hi(input int s, output int cnt);
    cnt = 0;
    while (sig(s) !== 1'h1 && cnt < 400) begin
      @(posedge pclk);
      #1;
      cnt++;
    end
    if (cnt >= 400) begin
      fail_count++;
      close_out();
    end
  endtask
  // Request is held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    if (k >= 16) begin
      fail_count++;
      close_out();
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    q.push_back(exp);
    apb(1'h0, a, 32'h0);
  endtask
  always @(posedge pclk) begin
    if (presetn && psel && penable && pready && !pwrite) begin
      if (q.size() == 0) check("read queue", 32'h1, 32'h0);
      else check("prdata", prdata, q.pop_front());
    end
  end
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    close_out();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, cnt_en} = 5'h0;
    {paddr, pwdata, req0, req1, lag} = '0;
    seed = 32'h75f5245a;
    fail_count = 0;
    n_compared = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    for (int a = 0; a < 32'h78; a += 4) rd(32'(a), 32'h0);
    for (int a = 0; a < 32'h78; a += 4) rd(32'h1000 + 32'(a), 32'h0);
    rd(32'h2, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(32'h1018 + 32'(4 * i), seed);
      rd(32'h1018 + 32'(4 * i), seed);
    end
    wr(32'h102c, seed);
    rd(32'h102c, 32'h0);
    wr(32'h0c, 32'h2);
    wr(32'h18, 32'h6);
    wr(32'h14, 32'h5);
    wr(32'h04, 32'h1);
    wait_hi(0, n);
    check("match delay", 32'(n), 32'h13);
    rd(32'h04, 32'h0);
    rd(32'h08, 32'h6);
    rd(32'h00, 32'h1);
    wr(32'h00, 32'h1);
    rd(32'h00, 32'h0);
    wr(32'h08, 32'h7b);
    wr(32'h28, 32'h5);
    @(posedge pclk);
    lag <= 2'h2;
    req0 <= 2'h1;
    wait_hi(0, n);
    rd(32'h2c, 32'h7b);
    rd(32'h00, 32'h10);
    wr(32'h00, 32'h3f);
    wr(32'h70, 32'h10);
    @(posedge pclk);
    req0 <= 2'h0;
    wait_hi(4, n);
    wr(32'h08, 32'h55);
    @(posedge pclk);
    req0 <= 2'h1;
    wait_hi(0, n);
    rd(32'h08, 32'h0);
    wr(32'h00, 32'h3f);
    wr(32'h70, 32'h0);
    for (int m = 1; m < 4; m++) begin
      seed = xs(seed);
      wr(32'h1070, 32'(m) | 32'h4);
      wr(32'h1008, 32'h0);
      wr(32'h1004, 32'h1);
      @(posedge pclk);
      lag <= seed[1:0];
      req1 <= 2'h2;
      wait_hi(2, n);
      @(posedge pclk);
      req1 <= 2'h0;
      wait_hi(3, n);
      // Three edges of synchroniser before the count moves
      repeat (4) @(posedge pclk);
      rd(32'h1008, (m == 3) ? 32'h2 : 32'h1);
    end
    wr(32'h1004, 32'h0);
    wr(32'h1070, 32'h0);
    wr(32'h08, 32'h0);
    wr(32'h0c, 32'h0);
    wr(32'h1c, 32'h3);
    wr(32'h3c, 32'h80);
    wr(32'h14, 32'h0);
    wr(32'h04, 32'h1);
    wait_hi(1, n);
    // The pin model counts the rise one edge after the output moves
    @(posedge pclk);
    #1;
    check("match rises", {24'h0, rs0}, 32'h1);
    rd(32'h3c, 32'h82);
    wr(32'h1008, 32'h0);
    wr(32'h1024, 32'h9);
    wr(32'h1018, 32'h4);
    wr(32'h1014, 32'h600);
    wr(32'h1074, 32'h1);
    wr(32'h1004, 32'h1);
    repeat (30) @(posedge pclk);
    cnt_en <= 1'h1;
    repeat (100) @(posedge pclk);
    cnt_en <= 1'h0;
    // Let the last enabled sample land in the pin model before reading it
    @(posedge pclk);
    #1;
    check("pwm high", {16'h0, hi1}, 32'h3c);
    wr(32'h1004, 32'h0);
    wr(32'h1000, 32'h3f);
    rd(32'h1000, 32'h0);
    close_out();
  end
endmodule // tmr_timer_tb
`default_nettype wire
